//--- verilog/strobe_delay_map.svh
`ifndef STROBE_DELAY_MAP_SVH
`define STROBE_DELAY_MAP_SVH

// group layout
`define PADS_PER_GROUP 16
`define STROBE_TRUE_PAD 4'h7
`define STROBE_COMP_PAD 4'h8
// tapped sample lines, one tap per system clock
`define LINE_DEPTH 32
`define TAP_W 5
`define CODE_W 9
`define PTR_W 3
`define CODE_RESET 9'h000
`define PTR_RESET 3'h0
// timing
`define SYS_PERIOD_NS 10
`define EDGE_PERIOD_NS 80
`define QUARTER_TAPS ((`EDGE_PERIOD_NS / 4 + `SYS_PERIOD_NS - 1) / `SYS_PERIOD_NS)
// read framing: window counted in edge clock periods, burst in strobe edges
`define WINDOW_EDGES 3'h4
`define BURST_STROBES 3'h4
`define CNT_ZERO 3'h0
`define CNT_ONE 3'h1

`endif

//--- verilog/strobe_delay_pkg.sv
`include "strobe_delay_map.svh"

package strobe_delay_pkg;

    typedef struct packed {
        logic load_n;
        logic move;
        logic direction;
    } margin_ctrl_t;

    typedef struct packed {
        logic [`PTR_W-1:0] read_ptr;
        logic [`PTR_W-1:0] write_ptr;
    } fifo_ptr_t;

    typedef enum logic [2:0] {
        FRAME_IDLE = 3'b001,
        FRAME_WAIT = 3'b010,
        FRAME_OPEN = 3'b100
    } frame_state_t;

endpackage

//--- verilog/strobe_delay_control_block.sv
`timescale 1ns/10ps
`include "strobe_delay_map.svh"
// What this block does
// - sixteen consecutive bottom pads form one group served by this block
// - two fixed pads carry true and complement strobe; others carry data or mask
// - incoming read strobe passes a programmable delay before capturing data
// - read delay line is a slave taking its setting from the master loop
// - a second slave line makes the delayed write clocks
// - write leveling adds its own offset to the write line via load_n, direction and move
// - read and write delays shift at run time via load_n, move, direction
// - block produces three-bit read and write pointers for the capture FIFO
// - pointers move read data safely from strobe domain into edge clock
// - a 90 degree delayed strobe is output as read capture clock
// - write strobe clock plus a 90 degree offset data write clock
// - controller drives 2-bit read request and 3-bit pulse select
// - valid-data output marks where captured read data starts
// - same pointers delivered to every pad cell of the group
module strobe_delay_control_block (
    input wire logic MCLK_I,
    input wire logic ARST_N_I,
    input wire logic STROBE_I,
    input wire logic STROBE_N_I,
    input wire logic EDGE_CLOCK_I,
    input wire logic [1:0] READ_REQUEST_I,
    input wire logic [2:0] READ_PULSE_SELECT_I,
    input wire strobe_delay_pkg::margin_ctrl_t READ_MARGIN_I,
    input wire strobe_delay_pkg::margin_ctrl_t WRITE_MARGIN_I,
    input wire strobe_delay_pkg::margin_ctrl_t LEVEL_ADJUST_I,
    input wire logic [`CODE_W-1:0] DELAY_CODE_IN_I,
    output logic READ_CAPTURE_STROBE_O,
    output logic STROBE_WRITE_CLOCK_O,
    output logic DATA_WRITE_CLOCK_O,
    output strobe_delay_pkg::fifo_ptr_t [`PADS_PER_GROUP-1:0] PAD_FIFO_POINTERS_O,
    output logic READ_DATA_START_O,
    output logic BURST_SEEN_O,
    output logic READ_DELAY_COUNT_FLAG_O,
    output logic WRITE_DELAY_COUNT_FLAG_O,
    output logic [`CODE_W-1:0] DELAY_CODE_OUT_O
);
    import strobe_delay_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: first stage feeds only the second
    logic [1:0] strobe_sync;
    logic [1:0] strobe_n_sync;
    logic [1:0] edge_sync;
    logic strobe_diff;
    logic edge_prev;
    logic edge_rise;

    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            strobe_sync <= 2'h0;
            strobe_n_sync <= 2'h3;
            edge_sync <= 2'h0;
            edge_prev <= 1'b0;
        end else begin
            strobe_sync <= {strobe_sync[0], STROBE_I};
            strobe_n_sync <= {strobe_n_sync[0], STROBE_N_I};
            edge_sync <= {edge_sync[0], EDGE_CLOCK_I};
            edge_prev <= edge_sync[1];
        end
    end

    // differential receive of the strobe pad pair
    assign strobe_diff = strobe_sync[1] & ~strobe_n_sync[1];
    assign edge_rise = edge_sync[1] & ~edge_prev;

    ////////////////////////////////////////////////////////////////////////////
    // margin offsets: 0 read, 1 write, 2 leveling
    margin_ctrl_t ctrl [3];
    logic [`CODE_W-1:0] offset [3];
    logic carry [3];
    logic move_prev [3];

    assign ctrl[0] = READ_MARGIN_I;
    assign ctrl[1] = WRITE_MARGIN_I;
    assign ctrl[2] = LEVEL_ADJUST_I;

    genvar m;
    generate
        for (m = 0; m < 3; m++) begin : g_margin
            // load wins over a move in the same cycle: offset snaps back to the master code
            always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
                if (!ARST_N_I) begin
                    offset[m] <= `CODE_RESET;
                    carry[m] <= 1'b0;
                    move_prev[m] <= 1'b0;
                end else begin
                    move_prev[m] <= ctrl[m].move;
                    if (!ctrl[m].load_n) begin
                        offset[m] <= `CODE_RESET;
                        carry[m] <= 1'b0;
                    end else if (ctrl[m].move && !move_prev[m]) begin
                        if (ctrl[m].direction) begin
                            offset[m] <= offset[m] - 9'h001;
                            carry[m] <= (offset[m] == `CODE_RESET);
                        end else begin
                            offset[m] <= offset[m] + 9'h001;
                            carry[m] <= (offset[m] == 9'h1ff);
                        end
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // slave delays follow the master code plus margin
    logic [`CODE_W-1:0] read_code;
    logic [`CODE_W-1:0] write_code;
    logic [`TAP_W-1:0] read_tap;
    logic [`TAP_W-1:0] strobe_w_tap;
    logic [`TAP_W-1:0] data_w_tap;

    assign read_code = DELAY_CODE_IN_I + offset[0];
    assign write_code = DELAY_CODE_IN_I + offset[1] + offset[2];
    // the tap range is short; codes wrap within the line rather than saturate
    assign read_tap = read_code[`TAP_W-1:0] + `TAP_W'(`QUARTER_TAPS);
    assign strobe_w_tap = write_code[`TAP_W-1:0];
    assign data_w_tap = write_code[`TAP_W-1:0] + `TAP_W'(`QUARTER_TAPS);

    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            DELAY_CODE_OUT_O <= `CODE_RESET;
            READ_DELAY_COUNT_FLAG_O <= 1'b0;
            WRITE_DELAY_COUNT_FLAG_O <= 1'b0;
        end else begin
            DELAY_CODE_OUT_O <= read_code;
            READ_DELAY_COUNT_FLAG_O <= carry[0];
            WRITE_DELAY_COUNT_FLAG_O <= carry[1] | carry[2];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // tapped delay lines
    logic [`LINE_DEPTH-1:0] strobe_line;
    logic [`LINE_DEPTH-1:0] edge_line;

    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            strobe_line <= '0;
            edge_line <= '0;
        end else begin
            strobe_line <= {strobe_line[`LINE_DEPTH-2:0], strobe_diff};
            edge_line <= {edge_line[`LINE_DEPTH-2:0], edge_sync[1]};
        end
    end

    logic capture_prev;
    logic capture_rise;

    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            READ_CAPTURE_STROBE_O <= 1'b0;
            STROBE_WRITE_CLOCK_O <= 1'b0;
            DATA_WRITE_CLOCK_O <= 1'b0;
            capture_prev <= 1'b0;
        end else begin
            READ_CAPTURE_STROBE_O <= strobe_line[read_tap];
            STROBE_WRITE_CLOCK_O <= edge_line[strobe_w_tap];
            DATA_WRITE_CLOCK_O <= edge_line[data_w_tap];
            capture_prev <= READ_CAPTURE_STROBE_O;
        end
    end

    assign capture_rise = READ_CAPTURE_STROBE_O & ~capture_prev;

    ////////////////////////////////////////////////////////////////////////////
    // read framing in edge clock periods
    frame_state_t state;
    logic [2:0] frame_cnt;
    logic [2:0] strobe_cnt;

    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            state <= FRAME_IDLE;
            frame_cnt <= `CNT_ZERO;
        end else if (edge_rise) begin
            case (state)
                FRAME_IDLE: begin
                    if (READ_REQUEST_I != 2'h0) begin
                        frame_cnt <= READ_PULSE_SELECT_I;
                        state <= FRAME_WAIT;
                    end
                end
                FRAME_WAIT: begin
                    if (frame_cnt == `CNT_ZERO) begin
                        frame_cnt <= `WINDOW_EDGES - `CNT_ONE;
                        state <= FRAME_OPEN;
                    end else begin
                        frame_cnt <= frame_cnt - `CNT_ONE;
                    end
                end
                FRAME_OPEN: begin
                    if (frame_cnt == `CNT_ZERO) begin
                        state <= FRAME_IDLE;
                    end else begin
                        frame_cnt <= frame_cnt - `CNT_ONE;
                    end
                end
                default: begin
                    state <= FRAME_IDLE;
                end
            endcase
        end
    end

    // strobe edges counted per window; a new request clears the burst flag
    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            strobe_cnt <= `CNT_ZERO;
            READ_DATA_START_O <= 1'b0;
            BURST_SEEN_O <= 1'b0;
        end else begin
            READ_DATA_START_O <= 1'b0;
            if (state == FRAME_IDLE) begin
                strobe_cnt <= `CNT_ZERO;
            end
            if (state == FRAME_OPEN && capture_rise) begin
                strobe_cnt <= strobe_cnt + `CNT_ONE;
                READ_DATA_START_O <= (strobe_cnt == `CNT_ZERO);
            end
            if (state == FRAME_OPEN && capture_rise && strobe_cnt == `BURST_STROBES - `CNT_ONE) begin
                BURST_SEEN_O <= 1'b1;
            end else if (state == FRAME_IDLE && edge_rise && READ_REQUEST_I != 2'h0) begin
                BURST_SEEN_O <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // fifo pointers: write side on delayed strobe, read side on edge clock
    logic [`PTR_W-1:0] write_ptr;
    logic [`PTR_W-1:0] read_ptr;
    logic [`PTR_W-1:0] write_ptr_seen [2];

    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            write_ptr <= `PTR_RESET;
        end else if (state == FRAME_OPEN && capture_rise) begin
            write_ptr <= write_ptr + 3'h1;
        end
    end

    // read side trails by two stages so an entry is never read while landing
    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            write_ptr_seen[0] <= `PTR_RESET;
            write_ptr_seen[1] <= `PTR_RESET;
            read_ptr <= `PTR_RESET;
        end else begin
            write_ptr_seen[0] <= write_ptr;
            write_ptr_seen[1] <= write_ptr_seen[0];
            if (edge_rise && read_ptr != write_ptr_seen[1]) begin
                read_ptr <= read_ptr + 3'h1;
            end
        end
    end

    genvar p;
    generate
        for (p = 0; p < `PADS_PER_GROUP; p++) begin : g_pad
            always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
                if (!ARST_N_I) begin
                    PAD_FIFO_POINTERS_O[p] <= '0;
                end else begin
                    PAD_FIFO_POINTERS_O[p].read_ptr <= read_ptr;
                    PAD_FIFO_POINTERS_O[p].write_ptr <= write_ptr;
                end
            end
        end
    endgenerate

endmodule

//--- tb/strobe_delay_properties.sv
`timescale 1ns/10ps
`include "strobe_delay_map.svh"
module strobe_delay_properties (
    input wire logic MCLK_I,
    input wire logic ARST_N_I,
    input wire strobe_delay_pkg::margin_ctrl_t READ_MARGIN_I,
    input wire strobe_delay_pkg::margin_ctrl_t WRITE_MARGIN_I,
    input wire strobe_delay_pkg::margin_ctrl_t LEVEL_ADJUST_I,
    input wire logic [`CODE_W-1:0] DELAY_CODE_IN_I,
    input wire logic STROBE_WRITE_CLOCK_O,
    input wire logic DATA_WRITE_CLOCK_O,
    input wire strobe_delay_pkg::fifo_ptr_t [`PADS_PER_GROUP-1:0] PAD_FIFO_POINTERS_O,
    input wire logic READ_DATA_START_O,
    input wire logic BURST_SEEN_O,
    input wire logic READ_DELAY_COUNT_FLAG_O,
    input wire logic WRITE_DELAY_COUNT_FLAG_O,
    input wire logic [`CODE_W-1:0] DELAY_CODE_OUT_O
);
    import strobe_delay_pkg::*;
    logic same;
    logic [5:0] calm;
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (!ARST_N_I);
    always_comb begin
        same = 1'b1;
        for (int i = 1; i < `PADS_PER_GROUP; i++) begin
            if (PAD_FIFO_POINTERS_O[i] != PAD_FIFO_POINTERS_O[0]) same = 1'b0;
        end
    end
    // write taps follow code and both margins, so phase is only judged once settled
    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) calm <= 6'h00;
        else if ($changed({DELAY_CODE_IN_I, WRITE_MARGIN_I, LEVEL_ADJUST_I})) calm <= 6'h00;
        else if (calm != 6'h3f) calm <= calm + 6'h01;
    end
    ////////////////////////////////////////////////////////////////////////////////
    pads_agree_a: assert property (same) else $error("pad pointers differ");
    start_pulse_a: assert property (READ_DATA_START_O |=> !READ_DATA_START_O)
        else $error("start pulse longer than one cycle");
    start_first_a: assert property (READ_DATA_START_O |-> !BURST_SEEN_O)
        else $error("start after burst flag");
    wr_ptr_step_a: assert property (!$stable(PAD_FIFO_POINTERS_O[0].write_ptr) |->
        PAD_FIFO_POINTERS_O[0].write_ptr == $past(PAD_FIFO_POINTERS_O[0].write_ptr) + 3'h1)
        else $error("write pointer jumped");
    rd_ptr_step_a: assert property (!$stable(PAD_FIFO_POINTERS_O[0].read_ptr) |->
        PAD_FIFO_POINTERS_O[0].read_ptr == $past(PAD_FIFO_POINTERS_O[0].read_ptr) + 3'h1)
        else $error("read pointer jumped");
    code_load_a: assert property (!READ_MARGIN_I.load_n |=> ##1
        DELAY_CODE_OUT_O == $past(DELAY_CODE_IN_I)) else $error("code after load wrong");
    code_step_a: assert property ($rose(READ_MARGIN_I.move) && READ_MARGIN_I.load_n
        ##1 READ_MARGIN_I.load_n |=> 9'(DELAY_CODE_OUT_O - $past(DELAY_CODE_IN_I)) ==
        9'($past(DELAY_CODE_OUT_O) - $past(DELAY_CODE_IN_I, 2)
        + ($past(READ_MARGIN_I.direction, 2) ? 9'h1ff : 9'h001)))
        else $error("code step wrong");
    write_phase_a: assert property (calm == 6'h3f |->
        DATA_WRITE_CLOCK_O == $past(STROBE_WRITE_CLOCK_O, 2)) else $error("write phase wrong");
    rd_flag_clear_a: assert property (!READ_MARGIN_I.load_n |-> ##[1:2]
        !READ_DELAY_COUNT_FLAG_O) else $error("read flag not cleared");
    wr_flag_clear_a: assert property (!WRITE_MARGIN_I.load_n && !LEVEL_ADJUST_I.load_n
        |-> ##[1:2] !WRITE_DELAY_COUNT_FLAG_O) else $error("write flag not cleared");
endmodule
bind strobe_delay_control_block strobe_delay_properties strobe_delay_properties_inst (
    .MCLK_I(MCLK_I), .ARST_N_I(ARST_N_I), .READ_MARGIN_I(READ_MARGIN_I),
    .WRITE_MARGIN_I(WRITE_MARGIN_I), .LEVEL_ADJUST_I(LEVEL_ADJUST_I),
    .DELAY_CODE_IN_I(DELAY_CODE_IN_I), .STROBE_WRITE_CLOCK_O(STROBE_WRITE_CLOCK_O),
    .DATA_WRITE_CLOCK_O(DATA_WRITE_CLOCK_O), .PAD_FIFO_POINTERS_O(PAD_FIFO_POINTERS_O),
    .READ_DATA_START_O(READ_DATA_START_O), .BURST_SEEN_O(BURST_SEEN_O),
    .READ_DELAY_COUNT_FLAG_O(READ_DELAY_COUNT_FLAG_O),
    .WRITE_DELAY_COUNT_FLAG_O(WRITE_DELAY_COUNT_FLAG_O), .DELAY_CODE_OUT_O(DELAY_CODE_OUT_O)
);

//--- tb/memory_strobe_model.sv
`timescale 1ns/10ps
module memory_strobe_model (
    input wire logic go_i,
    input wire logic [2:0] sel_i,
    input wire logic [4:0] lag_i,
    output logic strobe_o,
    output logic strobe_n_o
);
    initial begin
        strobe_o = 1'b0; // parked between bursts, complement opposite
        strobe_n_o = 1'b1;
    end
    // burst lands after the selected read pulse, one strobe per edge period
    // odd lead keeps strobe edges clear of the system clock's rising edge
    always @(posedge go_i) begin
        #(23 + (sel_i + 1) * 80 + lag_i);
        repeat (4) begin
            strobe_o = 1'b1; // edge aligned with data
            strobe_n_o = 1'b0;
            #40;
            strobe_o = 1'b0;
            strobe_n_o = 1'b1;
            #40;
        end
    end
endmodule

//--- tb/ddr_strobe_delay_control_bench.sv
`timescale 1ns/10ps
`include "strobe_delay_map.svh"
module ddr_strobe_delay_control_bench;
    import strobe_delay_pkg::*;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic edge_clk = 1'b0;
    logic go = 1'b0;
    logic [1:0] req = 2'h0;
    logic [2:0] sel = 3'h0;
    logic [4:0] lag = 5'h00;
    logic [8:0] code = 9'h000;
    logic [8:0] code_out;
    logic [2:0] wr_exp = 3'h0;
    logic strobe, strobe_n, start, burst, rd_flag, wr_flag;
    logic cap;
    logic cap_prev = 1'b0;
    logic [8:0] caps = 9'h000;
    logic [8:0] caps_exp = 9'h000;
    margin_ctrl_t ctl [3];
    fifo_ptr_t [`PADS_PER_GROUP-1:0] ptrs;
    int err_count = 0;
    int checked = 0;
    int n;
    always #5 mclk = ~mclk;
    // capture strobe rises counted away from its launching edge
    always @(negedge mclk) begin
        cap_prev <= cap;
        if (cap === 1'b1 && cap_prev === 1'b0) caps <= caps + 9'h001;
    end
    // edge clock phase kept off the system clock grid
    initial begin
        #3;
        forever #40 edge_clk = ~edge_clk;
    end
    strobe_delay_control_block strobe_delay_control_block_inst (
        .MCLK_I(mclk), .ARST_N_I(arst_n), .STROBE_I(strobe), .STROBE_N_I(strobe_n),
        .EDGE_CLOCK_I(edge_clk), .READ_REQUEST_I(req), .READ_PULSE_SELECT_I(sel),
        .READ_MARGIN_I(ctl[0]), .WRITE_MARGIN_I(ctl[1]), .LEVEL_ADJUST_I(ctl[2]),
        .DELAY_CODE_IN_I(code), .READ_CAPTURE_STROBE_O(cap), .STROBE_WRITE_CLOCK_O(),
        .DATA_WRITE_CLOCK_O(), .PAD_FIFO_POINTERS_O(ptrs), .READ_DATA_START_O(start),
        .BURST_SEEN_O(burst), .READ_DELAY_COUNT_FLAG_O(rd_flag),
        .WRITE_DELAY_COUNT_FLAG_O(wr_flag), .DELAY_CODE_OUT_O(code_out));
    memory_strobe_model memory_strobe_model_inst (.go_i(go), .sel_i(sel), .lag_i(lag),
        .strobe_o(strobe), .strobe_n_o(strobe_n));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic tick(input int k);
        repeat (k) @(negedge mclk);
    endtask
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        if (err_count == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic load(input logic [2:0] mask);
        foreach (ctl[i]) ctl[i].load_n = !mask[i];
        tick(1);
        foreach (ctl[i]) ctl[i].load_n = 1'b1;
        tick(2);
    endtask
    task automatic step(input int w, input logic dir);
        ctl[w].move = 1'b1;
        ctl[w].direction = dir;
        tick(1);
        ctl[w].move = 1'b0;
        tick(2);
    endtask
    task automatic wait_hi(input int s);
        for (int k = 0; k < 400; k++) begin
            tick(1);
            if ((s == 0) ? (start === 1'b1) : (burst === 1'b1)) return;
        end
        chk(9'h000, 9'h001);
        stop_test();
    endtask
    // request is raised just before an edge rise so the frame start is predictable
    task automatic frame(input logic [2:0] s, input logic [1:0] r);
        @(posedge edge_clk);
        tick(7);
        sel = s;
        req = r;
        lag = 5'($urandom_range(0, 1) * 10);
        go = 1'b1;
        wait_hi(0);
        chk(burst, 1'b0);
        req = 2'h0;
        go = 1'b0;
        wait_hi(1);
        tick(40);
        wr_exp = wr_exp + 3'h4;
        caps_exp = caps_exp + 9'h004;
        // whole group used as one data lane, strobe pads included
        chk(ptrs[$urandom_range(0, 15)].write_ptr, wr_exp);
        chk(ptrs[0].read_ptr, wr_exp);
        chk(caps, caps_exp);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        foreach (ctl[i]) ctl[i] = 3'b100;
        void'($urandom(32'h19d4_1a5d));
        tick(20);
        arst_n = 1'b1;
        tick(4);
        repeat (6) begin
            code = 9'($urandom);
            load(3'b001);
            chk(code_out, code);
            n = $urandom_range(1, 4);
            repeat (n) step(0, 1'b0);
            chk(code_out, code + 9'(n));
            step(0, 1'b1);
            chk(code_out, code + 9'(n) - 9'h001);
        end
        load(3'b111);
        step(0, 1'b1);
        chk(rd_flag, 1'b1);
        for (int w = 1; w < 3; w++) begin
            step(w, 1'b1);
            chk(wr_flag, 1'b1);
            load(3'b111);
            chk({rd_flag, wr_flag}, 2'b00);
        end
        // zero tap keeps the capture delay well inside the read window
        code = {4'($urandom), 5'h00};
        tick(70);
        for (int i = 0; i < 8; i++) frame(3'(i), 2'(i % 3 + 1));
        stop_test();
    end
endmodule
